/* File: sim/iop_pin_model.sv */
// Purpose: External hardware on the pins: drives inputs and strobes, resolves wires.
// Assumes: Bench never drives a pin that the device drives.
// Notes: An undriven pin without pull-down toggles, so a stale value never passes.
`timescale 1ns/100ps
`default_nettype none
module iop_pin_model (
  input wire logic clk,
  input wire logic [iop_pkg::NPINS-1:0] pin_out,
  input wire logic [iop_pkg::NPINS-1:0] pin_oe,
  input wire logic [iop_pkg::NPINS-1:0] pin_pulldown,
  input wire logic [iop_pkg::NPINS-1:0] ext_drive,
  input wire logic [iop_pkg::NPINS-1:0] ext_val,
  input wire logic strobe_req,
  output logic [iop_pkg::NPINS-1:0] pin_in,
  output logic [iop_pkg::NPORTS-1:0] input_strobe
);
  import iop_pkg::*;
  logic [NPINS-1:0] float_reg = 16'h5555;
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_drive[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_pulldown[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_reg[i];
      end
    end
    input_strobe = {NPORTS{strobe_req}};
  end
endmodule
`default_nettype wire

/* File: sim/iop_top_assertions.sv */
// Purpose: Port-level checks for the I/O port fabric, bound to the top module.
// Assumes: One clock domain; rst asynchronous, active high.
// Notes: Reset checks run while rst is high; all others are disabled in reset.
`timescale 1ns/100ps
`default_nettype none
module iop_top_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [iop_pkg::NPINS-1:0] pin_oe,
  input wire logic [iop_pkg::NPINS-1:0] pin_pulldown,
  input wire logic [iop_pkg::NPORTS-1:0] output_strobe,
  input wire logic [iop_pkg::NPORTS-1:0] port_event,
  input wire logic link_enable,
  input wire logic irq
);
  import iop_pkg::*;
  a_pull_in_reset: assert property (@(posedge clk) rst |-> pin_pulldown == '1)
    else $error("pull-down off during reset");
  a_quiet_reset: assert property (@(posedge clk) rst |->
    (pin_oe == '0) && (output_strobe == '0) && (port_event == '0) && !irq && !link_enable)
    else $error("outputs active during reset");
  a_first_wait: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in one cycle");
  a_wait_again: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && !avs_waitrequest ##1 (avs_read || avs_write) |-> avs_waitrequest)
    else $error("new access answered without wait cycle");
  a_idle_nowait: assert property (@(posedge clk) disable iff (rst)
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without access");
  a_read_hold: assert property (@(posedge clk) disable iff (rst)
    !avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  a_link_frees: assert property (@(posedge clk) disable iff (rst)
    link_enable |-> pin_oe[LINK_LO +: LINK_N] == '0)
    else $error("port drives a link pin");
  a_link_pull: assert property (@(posedge clk) disable iff (rst)
    link_enable && $past(link_enable) |-> pin_pulldown[LINK_LO +: LINK_N] == '0)
    else $error("pull-down left on link pins");
  a_drive_nopull: assert property (@(posedge clk) disable iff (rst)
    (pin_oe & $past(pin_oe) & pin_pulldown) == '0)
    else $error("pull-down on a driven pin");
endmodule
bind iop_top iop_top_assertions u_iop_top_assertions (
  .clk(clk),
  .rst(rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .pin_oe(pin_oe),
  .pin_pulldown(pin_pulldown),
  .output_strobe(output_strobe),
  .port_event(port_event),
  .link_enable(link_enable),
  .irq(irq)
);
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the I/O port fabric over its register bus.
// Assumes: Clock block 0 ticks every cycle; one wait cycle per access.
// Notes: Outputs are checked one edge after the access, two for the registered pull-downs, so its update has landed.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import iop_pkg::*;
  logic clk = 1'b0;
  logic rst;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NPINS-1:0] pin_in;
  logic [NPINS-1:0] pin_out;
  logic [NPINS-1:0] pin_oe;
  logic [NPINS-1:0] pin_pulldown;
  logic [NPINS-1:0] ext_drive = '0;
  logic [NPINS-1:0] ext_val = '0;
  logic strobe_req = 1'b1;
  logic [NPORTS-1:0] input_strobe;
  logic [NPORTS-1:0] output_strobe;
  logic [NPORTS-1:0] port_event;
  logic link_enable;
  logic irq;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  int err_total = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  iop_top u_iop_top (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pulldown(pin_pulldown), .input_strobe(input_strobe), .output_strobe(output_strobe),
    .port_event(port_event), .link_enable(link_enable), .irq(irq));
  iop_pin_model u_iop_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pulldown(pin_pulldown), .ext_drive(ext_drive), .ext_val(ext_val),
    .strobe_req(strobe_req), .pin_in(pin_in), .input_strobe(input_strobe));

  function automatic logic [8:0] pa(input int p, input logic [2:0] w);
    return PORT_BASE_OFS + 9'(p * 32) + {4'h0, w, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait: a stuck waitrequest must not hang the bus tasks
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk({31'h0, avs_waitrequest}, 32'h0);
  endtask

  task automatic bus_wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait;
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait;
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic wait_hi(input bit strb, input int p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((strb ? output_strobe[p] : port_event[p]) !== 1'b1 && n < 40);
    chk(32'(n < 40), 32'h1);
  endtask

  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    end_of_test;
  end

  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(pin_pulldown), 32'h0000_ffff);
    chk(32'(pin_oe), 32'h0);
    for (int i = 0; i < NPORTS; i++) begin
      bus_rd(pa(i, P_CTRL), rd_a);
      chk(rd_a, CTRL_RST);
    end
    bus_wr(CLKBLK_BASE_OFS, 32'h1ff);
    bus_rd(CLKBLK_BASE_OFS, rd_a);
    chk(rd_a, 32'h0);
    bus_wr(CLKBLK_BASE_OFS + 9'h014, 32'h3ff);
    bus_rd(CLKBLK_BASE_OFS + 9'h014, rd_a);
    chk(rd_a, 32'h1ff);
    bus_rd(9'h00c, rd_a);
    chk(rd_a, 32'h0);
    // Narrow input port under a wider output port
    ext_drive <= 16'h000f;
    ext_val <= 16'h000a;
    bus_wr(pa(2, P_CTRL), 32'h1);
    wait_hi(1'b0, 2);
    bus_rd(pa(2, P_DATA), rd_a);
    chk(rd_a, 32'h0000_000a);
    bus_wr(pa(3, P_CTRL), 32'h3);
    bus_wr(pa(3, P_DATA), 32'hff);
    wait_hi(1'b0, 3);
    chk(32'(pin_oe), 32'h00f0);
    chk(32'(pin_out & pin_oe), 32'h00f0);
    bus_wr(pa(2, P_CTRL), 32'h0);
    bus_wr(pa(3, P_CTRL), 32'h0);
    ext_drive <= '0;
    // Link takes the top pins from a driving 16-bit port
    bus_wr(pa(4, P_CTRL), 32'h3);
    bus_wr(pa(4, P_DATA), 32'hffff);
    wait_hi(1'b0, 4);
    chk(32'(pin_oe), 32'hffff);
    bus_wr(LINK_CTRL_OFS, 32'h1);
    @(posedge clk);
    @(posedge clk);
    chk(32'(pin_oe), 32'h0fff);
    chk(32'(pin_pulldown), 32'h0);
    bus_wr(LINK_CTRL_OFS, 32'h0);
    bus_wr(pa(4, P_CTRL), 32'h0);
    // Conditional start, two-slice word, strobe-in gating and overrun
    ext_drive <= 16'h00ff;
    ext_val <= 16'h000a;
    bus_wr(pa(3, P_COND), 32'h5);
    bus_wr(pa(3, P_CTRL), 32'h1009);
    bus_rd(pa(3, P_STATUS), rd_a);
    chk(rd_a & 32'hff, 32'h0);
    ext_val <= 16'h0005;
    wait_hi(1'b0, 3);
    bus_rd(pa(3, P_DATA), rd_a);
    chk(rd_a, 32'h0000_0505);
    strobe_req <= 1'b0;
    bus_wr(pa(3, P_CTRL), 32'h1041);
    bus_rd(pa(3, P_DATA), rd_a);
    bus_rd(pa(3, P_STATUS), rd_a);
    chk(rd_a & 32'hc0, 32'h80);
    strobe_req <= 1'b1;
    wait_hi(1'b0, 3);
    bus_wr(pa(3, P_CTRL), 32'h0);
    ext_drive <= '0;
    // Open collector, counter, timestamp
    bus_rd(IRQ_STATUS_OFS, rd_a);
    bus_wr(pa(0, P_CTRL), 32'h7);
    bus_wr(pa(0, P_DATA), 32'h0);
    wait_hi(1'b0, 0);
    chk({30'h0, pin_oe[0], pin_out[0]}, 32'h2);
    bus_wr(pa(0, P_DATA), 32'h1);
    wait_hi(1'b0, 0);
    chk({31'h0, pin_oe[0]}, 32'h0);
    bus_rd(pa(0, P_COUNT), rd_a);
    bus_rd(pa(0, P_COUNT), rd_b);
    chk((rd_b - rd_a) & 32'hffff, 32'h3);
    bus_rd(pa(0, P_TSTAMP), rd_b);
    chk(32'(rd_b[15:0] != 16'h0 && rd_b[15:0] < rd_a[15:0]), 32'h1);
    // Sticky status, mask and level interrupt
    chk({31'h0, irq}, 32'h0);
    bus_wr(IRQ_MASK_OFS, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus_rd(IRQ_STATUS_OFS, rd_a);
    chk(rd_a & 32'h1, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Outgoing strobe beside output data
    bus_wr(pa(1, P_CTRL), 32'h83);
    bus_wr(pa(1, P_DATA), 32'h1);
    wait_hi(1'b1, 1);
    end_of_test;
  end
endmodule
`default_nettype wire

/* File: src/iop_pkg.sv */
// Purpose: Shared constants for the I/O port and clock block fabric.
// Assumes: Avalon-MM register map with 32-bit words, byte addresses.
// Notes: Ports are listed narrowest first; pin ownership relies on that order.
package iop_pkg;
  localparam int ADDR_W = 9;
  localparam int NPINS = 16;
  localparam int NPORTS = 6;
  localparam int NCLKBLK = 6;
  localparam int CB_SEL_W = 3;
  localparam int CNT_W = 16;
  // Global register byte offsets
  localparam logic [8:0] IRQ_STATUS_OFS = 9'h000;
  localparam logic [8:0] IRQ_MASK_OFS = 9'h004;
  localparam logic [8:0] LINK_CTRL_OFS = 9'h008;
  localparam logic [8:0] CLKBLK_BASE_OFS = 9'h010;
  localparam logic [8:0] PORT_BASE_OFS = 9'h040;
  localparam logic [3:0] PORT_BASE_IDX = 4'h2;
  // Word index inside one port window (address bits 4:2)
  localparam logic [2:0] P_CTRL = 3'h0;
  localparam logic [2:0] P_DATA = 3'h1;
  localparam logic [2:0] P_COND = 3'h2;
  localparam logic [2:0] P_TIME = 3'h3;
  localparam logic [2:0] P_COUNT = 3'h4;
  localparam logic [2:0] P_TSTAMP = 3'h5;
  localparam logic [2:0] P_STATUS = 3'h6;
  // Port control fields
  localparam int CTL_EN = 0;
  localparam int CTL_OUT = 1;
  localparam int CTL_OC = 2;
  localparam int CTL_COND = 3;
  localparam int CTL_CNEQ = 4;
  localparam int CTL_TIMED = 5;
  localparam int CTL_SIN = 6;
  localparam int CTL_SOUT = 7;
  localparam int CTL_CB_LSB = 8;
  localparam int CTL_NS_LSB = 12;
  localparam int CTL_NS_W = 5;
  localparam logic [31:0] CTRL_MASK = 32'h0001_f7ff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Clock block configuration fields
  localparam int CB_DIV_W = 8;
  localparam int CB_EXT = 8;
  localparam logic [8:0] CB_CFG_MASK = 9'h1ff;
  localparam logic [8:0] CB_CFG_RST = 9'h000;
  localparam int CB_EXT_PIN = 0;
  // Port table: logical width, first pin, bonded pin count
  localparam int PORT_W [NPORTS] = '{1, 1, 4, 8, 16, 32};
  localparam int PORT_LO [NPORTS] = '{0, 1, 0, 0, 0, 0};
  localparam int PORT_PINS [NPORTS] = '{1, 1, 4, 8, 16, 16};
  // Pins taken over by the inter-chip link
  localparam int LINK_LO = 12;
  localparam int LINK_N = 4;
  localparam logic [NPINS-1:0] PULLDOWN_RST = 16'hffff;
endpackage

/* File: src/iop_top.sv */
// Functional notes
// - Each port is wholly input or wholly output, chosen by one direction bit.
// - Ports of width 1, 4, 8, 16 and 32 bits map onto pins.
// - Ports drive pins or sample them, optionally waiting on a pin condition.
// - Every register access by the core completes in one bus cycle; here each takes two, the first a wait cycle.
// - Open-collector mode per port: zero pulls low, one leaves pin undriven.
// - Data passes a shift serializer plus transfer register between pin and core.
// - Each port has a readable 16-bit counter that can delay a transfer.
// - Each transfer latches the counter as a timestamp for software.
// - An enabled link disconnects ports from its pins.
// - An enabled narrower port overrules wider ports on shared pins.
// - Unshared pins of a wider port stay with the wider port.
// - A port always transfers at its own width, whatever pins it keeps.
// - Six clock blocks; block zero is the reference, others programmable.
// - A clock block may take a 1-bit port pin as source, optionally divided.
// - Ports accept an input strobe and produce an output strobe.
// - After reset every port is attached to clock block zero.
// - Pin conditions become events straight to the core, not handlers.
// - During reset every pin has its weak pull-down enabled.
//
// Purpose: Pin-facing I/O ports with counters, serializers and clock blocks.
// Assumes: Single 50 MHz clock; clock block zero ticks every cycle.
// Notes: Reference rate is the system clock here, not a separate 100 MHz source.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module iop_port #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic wr,
  input wire logic rd,
  input wire logic rd_hold,
  input wire logic [2:0] word,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  input wire logic [W-1:0] pin_in,
  input wire logic input_strobe,
  output logic [W-1:0] out_val,
  output logic out_drive,
  output logic out_oc,
  output logic enabled,
  output logic output_strobe,
  output logic event_pulse,
  output logic [iop_pkg::CB_SEL_W-1:0] clk_sel
);
  import iop_pkg::*;
  localparam int MAXS = 32 / W;

  logic [31:0] ctrl_reg;
  logic [31:0] cond_reg;
  logic [CNT_W-1:0] time_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] tstamp_reg;
  logic [31:0] txr_reg;
  logic txr_full_reg;
  logic [31:0] sh_reg;
  logic [5:0] sl_reg;
  logic ovf_reg;
  logic [W-1:0] out_reg;
  logic ostb_reg;
  logic evt_reg;

  logic en, dir_out, go, time_ok, cond_ok, start_ok;
  logic [5:0] nsl;
  logic [31+W:0] cat;
  logic [31:0] sh_in;
  logic [31:0] in_word;
  logic [6:0] used_bits;
  logic in_step, in_done, out_step, out_load;

  assign en = ctrl_reg[CTL_EN];
  assign dir_out = ctrl_reg[CTL_OUT];
  assign clk_sel = ctrl_reg[CTL_CB_LSB +: CB_SEL_W];

  always_comb begin
    nsl = 6'(ctrl_reg[CTL_NS_LSB +: CTL_NS_W]) + 6'h01;
    if (nsl > 6'(MAXS)) begin
      nsl = 6'(MAXS);
    end
    used_bits = 7'(32) - 7'(nsl * 6'(W));
    cat = {pin_in, sh_reg};
    sh_in = cat[31+W:W];
    in_word = sh_in >> used_bits;
  end

  // Strobe-in gates both directions when enabled
  assign go = tick & en & (~ctrl_reg[CTL_SIN] | input_strobe);
  assign time_ok = ~ctrl_reg[CTL_TIMED] | (cnt_reg == time_reg);
  assign cond_ok = ~ctrl_reg[CTL_COND] |
                   (ctrl_reg[CTL_CNEQ] ? (pin_in != cond_reg[W-1:0]) : (pin_in == cond_reg[W-1:0]));
  assign start_ok = time_ok & cond_ok;
  // A pending data read freezes completion so the popped word is the one returned
  assign in_step = go & ~dir_out & ~rd_hold & ((sl_reg != 6'h00) | start_ok);
  assign in_done = in_step & (sl_reg + 6'h01 == nsl);
  assign out_step = go & dir_out & (sl_reg != 6'h00);
  assign out_load = go & dir_out & (sl_reg == 6'h00) & txr_full_reg & time_ok;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr && word == P_CTRL) begin
      ctrl_reg <= wdata & CTRL_MASK;
    end else if (in_done || out_load) begin
      ctrl_reg[CTL_TIMED] <= 1'b0;
      ctrl_reg[CTL_COND] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_reg <= 32'h0;
      time_reg <= '0;
    end else if (wr && word == P_COND) begin
      cond_reg <= wdata;
    end else if (wr && word == P_TIME) begin
      time_reg <= wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (tick && en) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tstamp_reg <= '0;
    end else if (in_done || out_load) begin
      tstamp_reg <= cnt_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 32'h0;
      sl_reg <= 6'h00;
      out_reg <= '0;
    end else if (in_step) begin
      sh_reg <= sh_in;
      sl_reg <= in_done ? 6'h00 : sl_reg + 6'h01;
    end else if (out_step) begin
      out_reg <= sh_reg[W-1:0];
      sh_reg <= sh_reg >> W;
      sl_reg <= sl_reg - 6'h01;
    end else if (out_load) begin
      out_reg <= txr_reg[W-1:0];
      sh_reg <= txr_reg >> W;
      sl_reg <= nsl - 6'h01;
    end
  end

  // Transfer register; hardware fill beats a same-cycle pop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txr_reg <= 32'h0;
      txr_full_reg <= 1'b0;
    end else if (in_done) begin
      txr_reg <= in_word;
      txr_full_reg <= 1'b1;
    end else if (out_load) begin
      txr_full_reg <= 1'b0;
    end else if (wr && word == P_DATA && dir_out && !txr_full_reg) begin
      txr_reg <= wdata;
      txr_full_reg <= 1'b1;
    end else if (rd && word == P_DATA && !dir_out) begin
      txr_full_reg <= 1'b0;
    end
  end

  // Overrun of the transfer register; read of status clears, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else if ((in_done && txr_full_reg) || (wr && word == P_DATA && dir_out && txr_full_reg)) begin
      ovf_reg <= 1'b1;
    end else if (rd && word == P_STATUS) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ostb_reg <= 1'b0;
    end else if (tick) begin
      ostb_reg <= ctrl_reg[CTL_SOUT] & en &
                  (dir_out ? (out_step | out_load) : ~txr_full_reg);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_reg <= 1'b0;
    end else begin
      evt_reg <= in_done | out_load;
    end
  end

  assign out_val = out_reg;
  assign out_drive = en & dir_out;
  assign out_oc = ctrl_reg[CTL_OC];
  assign enabled = en;
  assign output_strobe = ostb_reg;
  assign event_pulse = evt_reg;

  always_comb begin
    case (word)
      P_CTRL: rdata = ctrl_reg;
      P_DATA: rdata = txr_reg;
      P_COND: rdata = cond_reg;
      P_TIME: rdata = 32'(time_reg);
      P_COUNT: rdata = 32'(cnt_reg);
      P_TSTAMP: rdata = 32'(tstamp_reg);
      P_STATUS: rdata = {24'h0, ovf_reg, txr_full_reg, sl_reg};
      default: rdata = 32'h0;
    endcase
  end
endmodule

module iop_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [iop_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [iop_pkg::NPINS-1:0] pin_in,
  output logic [iop_pkg::NPINS-1:0] pin_out,
  output logic [iop_pkg::NPINS-1:0] pin_oe,
  output logic [iop_pkg::NPINS-1:0] pin_pulldown,
  input wire logic [iop_pkg::NPORTS-1:0] input_strobe,
  output logic [iop_pkg::NPORTS-1:0] output_strobe,
  output logic [iop_pkg::NPORTS-1:0] port_event,
  output logic link_enable,
  output logic irq
);
  import iop_pkg::*;

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic wr_acc, rd_acc;
  logic [31:0] rmux;
  logic [NPORTS-1:0] status_reg;
  logic [NPORTS-1:0] mask_reg;
  logic link_reg;
  logic [NPINS-1:0] pd_reg;
  logic [CB_DIV_W:0] cb_cfg_reg [NCLKBLK];
  logic [CB_DIV_W-1:0] cb_cnt_reg [NCLKBLK];
  logic [NCLKBLK-1:0] cb_tick;
  logic ext_prev_reg;
  logic ext_rise;
  logic port_sel;
  logic [2:0] pidx;
  logic [31:0] port_rdata [NPORTS];
  logic [31:0] port_out [NPORTS];
  logic [31:0] port_pin [NPORTS];
  logic [NPORTS-1:0] port_drive, port_oc, port_en;
  logic [CB_SEL_W-1:0] port_clk [NPORTS];
  logic [NPINS-1:0] owned;
  logic [2:0] owner [NPINS];

  // Every access answers on the second cycle, so no access can hang
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_acc = avs_write & ack_reg;
  assign rd_acc = avs_read & ack_reg;
  // Upper windows beyond the last port must not alias onto low ports
  assign port_sel = (avs_address[8:5] >= PORT_BASE_IDX) &&
                    (avs_address[8:5] < PORT_BASE_IDX + 4'(NPORTS));
  assign pidx = 3'(avs_address[8:5] - PORT_BASE_IDX);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  always_comb begin
    rmux = 32'h0;
    if (port_sel) begin
      if (pidx < 3'(NPORTS)) begin
        rmux = port_rdata[pidx];
      end
    end else if (avs_address == IRQ_STATUS_OFS) begin
      rmux = 32'(status_reg);
    end else if (avs_address == IRQ_MASK_OFS) begin
      rmux = 32'(mask_reg);
    end else if (avs_address == LINK_CTRL_OFS) begin
      rmux = 32'(link_reg);
    end else if (avs_address[8:2] >= CLKBLK_BASE_OFS[8:2] &&
                 avs_address[8:2] < CLKBLK_BASE_OFS[8:2] + 7'(NCLKBLK)) begin
      rmux = 32'(cb_cfg_reg[3'(avs_address[8:2] - CLKBLK_BASE_OFS[8:2])]);
    end
  end

  // Read data is captured while waitrequest is high and stands at the accepting edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      rdata_reg <= rmux;
    end
  end
  assign avs_readdata = rdata_reg;

  // Sticky event bits; a read clears only what it returned, so an event in the wait cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
    end else if (rd_acc && avs_address == IRQ_STATUS_OFS) begin
      status_reg <= (status_reg & ~rdata_reg[NPORTS-1:0]) | port_event;
    end else begin
      status_reg <= status_reg | port_event;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= '0;
    end else if (wr_acc && avs_address == IRQ_MASK_OFS) begin
      mask_reg <= avs_writedata[NPORTS-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_reg <= 1'b0;
    end else if (wr_acc && avs_address == LINK_CTRL_OFS) begin
      link_reg <= avs_writedata[0];
    end
  end

  assign irq = |(status_reg & mask_reg);
  assign link_enable = link_reg;

  // External clock source: rising edges on the 1-bit port pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= pin_in[CB_EXT_PIN];
    end
  end
  assign ext_rise = pin_in[CB_EXT_PIN] & ~ext_prev_reg;

  // Block zero is the reference and ticks every cycle; others divide their source
  assign cb_tick[0] = 1'b1;
  assign cb_cfg_reg[0] = CB_CFG_RST;
  assign cb_cnt_reg[0] = '0;
  for (genvar n = 1; n < NCLKBLK; n++) begin : g_cb
    logic src;
    assign src = cb_cfg_reg[n][CB_EXT] ? ext_rise : 1'b1;
    assign cb_tick[n] = src & (cb_cnt_reg[n] == cb_cfg_reg[n][CB_DIV_W-1:0]);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cb_cfg_reg[n] <= CB_CFG_RST;
      end else if (wr_acc && avs_address == CLKBLK_BASE_OFS + 9'(4 * n)) begin
        cb_cfg_reg[n] <= avs_writedata[CB_DIV_W:0] & CB_CFG_MASK;
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cb_cnt_reg[n] <= '0;
      end else if (wr_acc && avs_address == CLKBLK_BASE_OFS + 9'(4 * n)) begin
        cb_cnt_reg[n] <= '0;
      end else if (cb_tick[n]) begin
        cb_cnt_reg[n] <= '0;
      end else if (src) begin
        cb_cnt_reg[n] <= cb_cnt_reg[n] + 8'h01;
      end
    end
  end

  // Pin ownership: ports scanned widest first so the narrowest enabled port wins, link pins excluded
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      owned[p] = 1'b0;
      owner[p] = 3'h0;
      for (int i = NPORTS - 1; i >= 0; i--) begin
        if (port_en[i] && p >= PORT_LO[i] && p < PORT_LO[i] + PORT_PINS[i]) begin
          owned[p] = 1'b1;
          owner[p] = 3'(i);
        end
      end
      if (link_reg && p >= LINK_LO && p < LINK_LO + LINK_N) begin
        owned[p] = 1'b0;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      pin_out[p] = 1'b0;
      pin_oe[p] = 1'b0;
      if (owned[p] && port_drive[owner[p]]) begin
        pin_out[p] = port_oc[owner[p]] ? 1'b0 : port_out[owner[p]][p - PORT_LO[owner[p]]];
        pin_oe[p] = port_oc[owner[p]] ? ~port_out[owner[p]][p - PORT_LO[owner[p]]] : 1'b1;
      end
    end
    for (int i = 0; i < NPORTS; i++) begin
      port_pin[i] = 32'h0;
      for (int b = 0; b < PORT_PINS[i]; b++) begin
        if (owned[PORT_LO[i] + b] && owner[PORT_LO[i] + b] == 3'(i)) begin
          port_pin[i][b] = pin_in[PORT_LO[i] + b];
        end
      end
    end
  end

  // Pull-downs on in reset, later on any pin no port or link holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_reg <= PULLDOWN_RST;
    end else begin
      pd_reg <= ~owned & ~(link_reg ? 16'(((1 << LINK_N) - 1) << LINK_LO) : 16'h0000);
    end
  end
  assign pin_pulldown = pd_reg;

  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    logic [PORT_W[i]-1:0] ov;
    logic sel;
    logic tk;
    assign sel = port_sel & (pidx == 3'(i));
    // Selecting a clock block that does not exist stalls the port
    assign tk = (port_clk[i] < 3'(NCLKBLK)) ? cb_tick[port_clk[i]] : 1'b0;
    iop_port #(
      .W(PORT_W[i])
    ) u_port (
      .clk(clk),
      .rst(rst),
      .tick(tk),
      .wr(wr_acc & sel),
      .rd(rd_acc & sel),
      .rd_hold(avs_read & sel & (avs_address[4:2] == P_DATA)),
      .word(avs_address[4:2]),
      .wdata(avs_writedata),
      .rdata(port_rdata[i]),
      .pin_in(port_pin[i][PORT_W[i]-1:0]),
      .input_strobe(input_strobe[i]),
      .out_val(ov),
      .out_drive(port_drive[i]),
      .out_oc(port_oc[i]),
      .enabled(port_en[i]),
      .output_strobe(output_strobe[i]),
      .event_pulse(port_event[i]),
      .clk_sel(port_clk[i])
    );
    assign port_out[i] = 32'(ov);
  end
endmodule

`default_nettype wire
